// ==== cmu_cache_maint_unit.sv ====
// cache maintenance sequencer for the enhanced addressing cache instruction
`timescale 1ns/1ps
`default_nettype none
module cmu_cache_maint_unit
(
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   // pipeline side
   input  wire logic        req_valid_in,
   input  wire logic [31:0] instr_in,
   input  wire logic [31:0] base_in,
   input  wire logic        eva_present_flag_in,
   input  wire logic [1:0]  seg_mode_in,
   input  wire logic        cacheability_attribute_coherent_in,
   input  wire logic [31:0] tag_stage_low_in,
   input  wire logic [31:0] tag_stage_high_in,
   input  wire logic        inclusive_in,
   input  wire logic [3:0]  write_through_in,
   output var  logic        busy_out,
   output var  logic        done_out,
   output var  logic        reserved_instr_out,
   output var  logic        cache_err_out,
   output var  logic        user_map_out,
   output var  logic [31:0] ea_out,
   output var  logic        stage_load_out,
   output var  logic [31:0] tag_stage_low_out,
   output var  logic [31:0] tag_stage_high_out,
   output var  logic [31:0] data_stage_low_out,
   output var  logic [31:0] data_stage_high_out,
   // cache array side
   input  wire logic        mem_idle_in,
   input  wire logic        cache_ack_in,
   input  wire logic        cache_valid_in,
   input  wire logic        cache_dirty_in,
   input  wire logic [31:0] cache_tag_lo_in,
   input  wire logic [31:0] cache_tag_hi_in,
   input  wire logic [31:0] cache_data_lo_in,
   input  wire logic [31:0] cache_data_hi_in,
   input  wire logic        wb_ack_in,
   input  wire logic        wb_err_in,
   output var  logic        cache_req_out,
   output var  logic [1:0]  cache_sel_out,
   output var  logic [1:0]  cache_cmd_out,
   output var  logic [31:0] cache_wtag_lo_out,
   output var  logic [31:0] cache_wtag_hi_out,
   output var  logic        global_out,
   output var  logic        wb_req_out
);

   //-------------------------------------------------------------------------
   // state
   //-------------------------------------------------------------------------
   typedef struct packed {
      cmu_pkg::cmu_state_t st;
      logic [2:0]          op;
      logic [1:0]          tgt;
      logic                outer;
      logic                busy;
      logic                done;
      logic                ri;
      logic                cerr;
      logic                umap;
      logic [31:0]         ea;
      logic                ld;
      logic [31:0]         tlo;
      logic [31:0]         thi;
      logic [31:0]         dlo;
      logic [31:0]         dhi;
      logic                creq;
      logic [1:0]          sel;
      logic [1:0]          cmd;
      logic [31:0]         wlo;
      logic [31:0]         whi;
      logic                glob;
      logic                wbreq;
   } cmu_regs_t;

   logic        rst_b;
   logic [31:0] ea_calc;
   cmu_regs_t   r_q;
   cmu_regs_t   r_d;

   //-------------------------------------------------------------------------
   // helpers
   //-------------------------------------------------------------------------
   // reset is held until two clean edges
   cmu_rst_sync u_rst
   (
      .clk_in    (clk_in),
      .rst_b_in  (rst_b_in),
      .rst_b_out (rst_b)
   );

   // address is formed straight from the request word
   cmu_ea_gen u_ea
   (
      .base_in (base_in),
      .ofs_in  (instr_in[cmu_pkg::OFS_MSB:cmu_pkg::OFS_LSB]),
      .ea_out  (ea_calc)
   );

   //-------------------------------------------------------------------------
   // sequencer
   //-------------------------------------------------------------------------
   // one request at a time; busy drops only back in idle
   always_comb
   begin
      r_d      = r_q;
      r_d.done = 1'b0;
      r_d.ri   = 1'b0;
      r_d.ld   = 1'b0;
      case (r_q.st)
         cmu_pkg::ST_IDLE:
         begin
            r_d.cerr = 1'b0;
            r_d.glob = 1'b0;
            if (req_valid_in)
            begin
               if (!eva_present_flag_in)
               begin
                  r_d.ri = 1'b1;
                  r_d.done = 1'b1;
               end
               else
               begin
                  r_d.busy = 1'b1;
                  r_d.op  = instr_in[cmu_pkg::OP_MSB:cmu_pkg::OP_LSB];
                  r_d.tgt = instr_in[cmu_pkg::TGT_MSB:cmu_pkg::TGT_LSB];
                  r_d.ea  = ea_calc;
                  r_d.umap = (seg_mode_in == cmu_pkg::SEG_MAPPED_USER_SUP_UNMAPPED_KERNEL_SEG);
                  // only hit ops may go global
                  // one choice kept for every level
                  r_d.glob = cacheability_attribute_coherent_in &
                             instr_in[cmu_pkg::OP_MSB];
                  r_d.wlo = tag_stage_low_in;
                  r_d.whi = tag_stage_high_in;
                  r_d.outer = inclusive_in &&
                     cmu_pkg::cmu_outer(instr_in[cmu_pkg::TGT_MSB:cmu_pkg::TGT_LSB]) &&
                     (instr_in[cmu_pkg::OP_MSB:cmu_pkg::OP_LSB] == cmu_pkg::OP_IDX_INV);
                  r_d.sel = r_d.outer ? cmu_pkg::TGT_D
                                      : instr_in[cmu_pkg::TGT_MSB:cmu_pkg::TGT_LSB];
                  r_d.st = cmu_pkg::ST_DRAIN;
               end
            end
         end
         cmu_pkg::ST_DRAIN:
         begin
            if (mem_idle_in)
            begin
               if (!cmu_pkg::cmu_present(r_q.tgt))
               begin
                  r_d.st = cmu_pkg::ST_DONE;
               end
               else
               begin
                  case (r_q.op)
                     cmu_pkg::OP_IDX_INV:
                     begin
                        r_d.creq = 1'b1;
                        if ((r_q.sel == cmu_pkg::TGT_I) || write_through_in[r_q.sel])
                        begin
                           r_d.cmd = cmu_pkg::CMD_INV;
                           r_d.st  = cmu_pkg::ST_INV;
                        end
                        else
                        begin
                           r_d.cmd = cmu_pkg::CMD_RD_TAG;
                           r_d.st  = cmu_pkg::ST_READ;
                        end
                     end
                     cmu_pkg::OP_LD_TAG:
                     begin
                        r_d.creq = 1'b1;
                        r_d.cmd  = cmu_pkg::CMD_RD_TAG;
                        r_d.st   = cmu_pkg::ST_READ;
                     end
                     cmu_pkg::OP_ST_TAG:
                     begin
                        r_d.creq = 1'b1;
                        r_d.cmd  = cmu_pkg::CMD_WR_TAG;
                        r_d.st   = cmu_pkg::ST_STORE;
                     end
                     default:
                     begin
                        // other codes are handled elsewhere
                        r_d.st = cmu_pkg::ST_DONE;
                     end
                  endcase
               end
            end
         end
         cmu_pkg::ST_READ:
         begin
            if (cache_ack_in)
            begin
               r_d.creq = 1'b0;
               if (r_q.op == cmu_pkg::OP_LD_TAG)
               begin
                  r_d.tlo = cache_tag_lo_in;
                  r_d.thi = cache_tag_hi_in;
                  r_d.dlo = cache_data_lo_in;
                  r_d.dhi = cache_data_hi_in;
                  r_d.ld  = 1'b1;
                  r_d.st  = cmu_pkg::ST_DONE;
               end
               else if (cache_valid_in && cache_dirty_in)
               begin
                  r_d.wbreq = 1'b1;
                  r_d.st    = cmu_pkg::ST_WB;
               end
               else
               begin
                  r_d.creq = 1'b1;
                  r_d.cmd  = cmu_pkg::CMD_INV;
                  r_d.st   = cmu_pkg::ST_INV;
               end
            end
         end
         cmu_pkg::ST_WB:
         begin
            if (wb_ack_in)
            begin
               r_d.wbreq = 1'b0;
               // error reported only from writeback
               if (wb_err_in)
               begin
                  r_d.cerr = 1'b1;
                  r_d.st   = cmu_pkg::ST_DONE;
               end
               else
               begin
                  r_d.creq = 1'b1;
                  r_d.cmd  = cmu_pkg::CMD_INV;
                  r_d.st   = cmu_pkg::ST_INV;
               end
            end
         end
         cmu_pkg::ST_INV:
         begin
            if (cache_ack_in)
            begin
               r_d.creq = 1'b0;
               // now the outer level, after a drain
               if (r_q.outer)
               begin
                  r_d.outer = 1'b0;
                  r_d.sel   = r_q.tgt;
                  r_d.st    = cmu_pkg::ST_DRAIN;
               end
               else
               begin
                  r_d.st = cmu_pkg::ST_DONE;
               end
            end
         end
         cmu_pkg::ST_STORE:
         begin
            if (cache_ack_in)
            begin
               r_d.creq = 1'b0;
               r_d.st   = cmu_pkg::ST_DONE;
            end
         end
         cmu_pkg::ST_DONE:
         begin
            // complete only once traffic has drained
            // load tag never sets the error
            if (mem_idle_in)
            begin
               r_d.done = 1'b1;
               r_d.busy = 1'b0;
               r_d.st   = cmu_pkg::ST_IDLE;
            end
         end
         default:
         begin
            r_d.st   = cmu_pkg::ST_IDLE;
            r_d.busy = 1'b0;
            r_d.creq = 1'b0;
            r_d.wbreq = 1'b0;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_in or negedge rst_b)
   begin
      if (!rst_b)
      begin
         r_q       <= '0;
         r_q.st    <= cmu_pkg::ST_IDLE;
         r_q.ea    <= cmu_pkg::WORD_RST;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   //-------------------------------------------------------------------------
   // outputs, all from flops
   //-------------------------------------------------------------------------
   assign busy_out            = r_q.busy;
   assign done_out            = r_q.done;
   assign reserved_instr_out  = r_q.ri;
   assign cache_err_out       = r_q.cerr;
   assign user_map_out        = r_q.umap;
   assign ea_out              = r_q.ea;
   assign stage_load_out      = r_q.ld;
   assign tag_stage_low_out   = r_q.tlo;
   assign tag_stage_high_out  = r_q.thi;
   assign data_stage_low_out  = r_q.dlo;
   assign data_stage_high_out = r_q.dhi;
   assign cache_req_out       = r_q.creq;
   assign cache_sel_out       = r_q.sel;
   assign cache_cmd_out       = r_q.cmd;
   assign cache_wtag_lo_out   = r_q.wlo;
   assign cache_wtag_hi_out   = r_q.whi;
   assign global_out          = r_q.glob;
   assign wb_req_out          = r_q.wbreq;

endmodule
`default_nettype wire

// ==== cmu_cache_maint_unit_chk.sv ====
// assertion checker for the cache maintenance unit
`timescale 1ns/1ps
`default_nettype none
module cmu_cache_maint_unit_chk
(
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   input wire logic        req_valid_in,
   input wire logic [31:0] instr_in,
   input wire logic        eva_present_flag_in,
   input wire logic        mem_idle_in,
   input wire logic        cache_ack_in,
   input wire logic        cache_valid_in,
   input wire logic        cache_dirty_in,
   input wire logic        wb_ack_in,
   input wire logic        wb_err_in,
   input wire logic        busy_out,
   input wire logic        done_out,
   input wire logic        reserved_instr_out,
   input wire logic        cache_err_out,
   input wire logic        stage_load_out,
   input wire logic        cache_req_out,
   input wire logic [1:0]  cache_cmd_out,
   input wire logic        global_out,
   input wire logic        wb_req_out
);
   logic       acc;
   logic [2:0] op_q;
   logic [1:0] tgt_q;

   // a request is taken only while idle
   assign acc = req_valid_in && !busy_out && !done_out;

   // op and target of the instruction in flight
   always_ff @(posedge clk_in or negedge rst_b_in)
      if (!rst_b_in)
      begin
         op_q  <= 3'h0;
         tgt_q <= 2'h0;
      end
      else if (acc)
      begin
         op_q  <= instr_in[cmu_pkg::OP_MSB:cmu_pkg::OP_LSB];
         tgt_q <= instr_in[cmu_pkg::TGT_MSB:cmu_pkg::TGT_LSB];
      end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   sequence s_trap;
      acc && !eva_present_flag_in;
   endsequence
   sequence s_rd_ack;
      cache_req_out && cache_ack_in && cache_cmd_out == cmu_pkg::CMD_RD_TAG
         && op_q == cmu_pkg::OP_IDX_INV;
   endsequence

   a_trap_signal: assert property (s_trap |=> reserved_instr_out && done_out)
      else $error("trap missing");
   a_dirty_wb: assert property (s_rd_ack |=> wb_req_out == $past(cache_valid_in && cache_dirty_in))
      else $error("writeback choice wrong");
   a_wb_then_inv: assert property (wb_req_out && wb_ack_in && !wb_err_in |=> cache_req_out && cache_cmd_out == cmu_pkg::CMD_INV)
      else $error("no invalidate after writeback");
   a_drain_first: assert property ($rose(busy_out) && !mem_idle_in |=> !cache_req_out)
      else $error("cache touched before drain");
   a_req_hold: assert property (cache_req_out && !cache_ack_in |=> cache_req_out && $stable(cache_cmd_out))
      else $error("cache request dropped");
   a_wb_hold: assert property (wb_req_out && !wb_ack_in |=> wb_req_out)
      else $error("writeback request dropped");
   a_absent_quiet: assert property (busy_out && tgt_q == cmu_pkg::TGT_T |-> !cache_req_out && !wb_req_out)
      else $error("absent level touched");
   a_icache_no_wb: assert property (busy_out && tgt_q == cmu_pkg::TGT_I |-> !wb_req_out)
      else $error("icache writeback");
   a_no_global: assert property (done_out && !op_q[2] |-> !global_out)
      else $error("index op broadcast");
   a_global_keep: assert property (busy_out && $past(busy_out) |-> $stable(global_out))
      else $error("broadcast changed mid op");
   a_stage_clean: assert property (stage_load_out |-> busy_out && op_q == cmu_pkg::OP_LD_TAG && !cache_err_out)
      else $error("bad stage load");
endmodule
bind cmu_cache_maint_unit cmu_cache_maint_unit_chk chk_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
   .req_valid_in(req_valid_in), .instr_in(instr_in), .eva_present_flag_in(eva_present_flag_in),
   .mem_idle_in(mem_idle_in), .cache_ack_in(cache_ack_in), .cache_valid_in(cache_valid_in),
   .cache_dirty_in(cache_dirty_in), .wb_ack_in(wb_ack_in), .wb_err_in(wb_err_in),
   .busy_out(busy_out), .done_out(done_out), .reserved_instr_out(reserved_instr_out),
   .cache_err_out(cache_err_out), .stage_load_out(stage_load_out),
   .cache_req_out(cache_req_out), .cache_cmd_out(cache_cmd_out), .global_out(global_out),
   .wb_req_out(wb_req_out));
`default_nettype wire

// ==== cmu_cache_maint_unit_tb.sv ====
// self-checking bench for the cache maintenance unit
`timescale 1ns/1ps
`default_nettype none
module cmu_cache_maint_unit_tb;
   logic        clk_in;
   logic        rst_b_in = 1'b0;
   logic        req = 1'b0, flag = 1'b1, coh = 1'b0, incl = 1'b0;
   logic        drt = 1'b0, werr = 1'b0, stall = 1'b0;
   logic [31:0] instr = 32'h0, base = 32'h0, tslo = 32'h0, lfsr = 32'h141c;
   logic [1:0]  seg = 2'h0, dly = 2'h0;
   logic [3:0]  wt = 4'h0;
   logic        busy, done, ri, cerr, umap, sload, creq, glob, wbreq, ack, vld, cdrt, wack, wer;
   logic        idle;
   logic [31:0] ea, slo, shi, sdlo, sdhi, wtlo, wthi, tlo, thi, dlo, dhi;
   logic [1:0]  csel, ccmd;
   logic [15:0] n_inv, n_wb, n_wr;
   int          errors = 0, check_count = 0;

   cmu_cache_maint_unit dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_valid_in(req),
      .instr_in(instr), .base_in(base), .eva_present_flag_in(flag), .seg_mode_in(seg),
      .cacheability_attribute_coherent_in(coh), .tag_stage_low_in(tslo),
      .tag_stage_high_in(~tslo), .inclusive_in(incl), .write_through_in(wt), .busy_out(busy),
      .done_out(done), .reserved_instr_out(ri), .cache_err_out(cerr), .user_map_out(umap),
      .ea_out(ea), .stage_load_out(sload), .tag_stage_low_out(slo), .tag_stage_high_out(shi),
      .data_stage_low_out(sdlo), .data_stage_high_out(sdhi), .mem_idle_in(idle),
      .cache_ack_in(ack), .cache_valid_in(vld), .cache_dirty_in(cdrt), .cache_tag_lo_in(tlo),
      .cache_tag_hi_in(thi), .cache_data_lo_in(dlo), .cache_data_hi_in(dhi), .wb_ack_in(wack),
      .wb_err_in(wer), .cache_req_out(creq), .cache_sel_out(csel), .cache_cmd_out(ccmd),
      .cache_wtag_lo_out(wtlo), .cache_wtag_hi_out(wthi), .global_out(glob), .wb_req_out(wbreq));
   cmu_cache_model mdl_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .cache_req_in(creq),
      .cache_sel_in(csel), .cache_cmd_in(ccmd), .wb_req_in(wbreq), .dly_in(dly), .dirty_in(drt),
      .wb_err_in(werr), .stall_in(stall), .cache_ack_out(ack), .wb_ack_out(wack),
      .inv_n_out(n_inv), .wr_n_out(n_wr), .wb_n_out(n_wb), .valid_out(vld), .dirty_out(cdrt),
      .wb_err_out(wer), .mem_idle_out(idle), .tag_lo_out(tlo), .tag_hi_out(thi),
      .data_lo_out(dlo), .data_hi_out(dhi));

   // 100 ns clock
   initial
   begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   function automatic logic [31:0] nxt(input logic [31:0] v);
      nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (!ok)
      begin
         errors++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   task automatic end_of_test;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // fresh random setting of the side inputs other than flag and stall
   task automatic rnd;
      repeat (8) lfsr = nxt(lfsr);
      {wt, seg, coh, drt, dly} = lfsr[19:10];
      base = lfsr;
      incl = lfsr[20];
      werr = lfsr[21] & lfsr[22] & !lfsr[20];
      tslo = ~lfsr;
   endtask

   // expected traffic of index invalidate on one level
   task automatic lvl(input logic [1:0] lv, inout int i, inout int w, inout logic e);
      if (wt[lv] || lv == cmu_pkg::TGT_I)
         i++;
      else if (drt)
      begin
         w++;
         if (werr)
            e = 1'b1;
         else
            i++;
      end
      else
         i++;
   endtask

   task automatic run(input logic [2:0] op, input logic [1:0] tg);
      int          i, w, r, k, i0, w0, r0;
      logic        e, sl, live, sg;
      logic [31:0] tv;
      {i, w, r, k} = '0;
      e = 1'b0;
      sg = 1'b0;
      {i0, w0, r0} = {int'(n_inv), int'(n_wb), int'(n_wr)};
      live = flag && tg != cmu_pkg::TGT_T;
      sl = live && op == cmu_pkg::OP_LD_TAG;
      tv = 32'h7a5c_0000 + {30'h0, tg};
      if (live && op == cmu_pkg::OP_IDX_INV)
      begin
         if (incl && tg == cmu_pkg::TGT_S)
            lvl(cmu_pkg::TGT_D, i, w, e);
         lvl(tg, i, w, e);
      end
      r = (live && op == cmu_pkg::OP_ST_TAG) ? 1 : 0;
      instr = {lfsr[31:26], op, tg, lfsr[20:0]};
      @(posedge clk_in);
      #1;
      req = 1'b1;
      stall = lfsr[3];
      @(posedge clk_in);
      #1;
      // a second request while busy must be ignored
      req = flag & lfsr[4];
      instr = instr ^ 32'h0380_0000;
      stall = 1'b0;
      while (done !== 1'b1 && k < 300)
      begin
         @(posedge clk_in);
         #1;
         req = 1'b0;
         sg = sg | (sload === 1'b1);
         k++;
      end
      if (done !== 1'b1)
      begin
         errors++;
         end_of_test();
      end
      chk(ri === !flag, "trap flag");
      chk(int'(n_inv) - i0 == i && int'(n_wb) - w0 == w, "cache traffic");
      chk(int'(n_wr) - r0 == r && cerr === e, "store or error");
      chk(sg === sl && sload === 1'b0, "stage load");
      if (sl)
         chk(slo === tv && shi === {tv[27:0], 4'h0} && sdhi === ~sdlo, "stage words");
      if (sl)
         chk(sdlo === (tv ^ 32'h00ff_00ff), "data stage");
      if (r == 1)
         chk(wtlo === tslo && wthi === ~tslo, "store tag words");
      if (flag)
      begin
         chk(ea === base + {{23{instr[8]}}, instr[8:0]}, "address");
         chk(umap === (seg == cmu_pkg::SEG_MAPPED_USER_SUP_UNMAPPED_KERNEL_SEG), "user mapping");
         chk(glob === (op[2] & coh), "broadcast");
      end
      @(posedge clk_in);
      #1;
      req = 1'b0;
   endtask

   // main sequence
   initial
   begin
      repeat (12) @(posedge clk_in);
      #1;
      rst_b_in = 1'b1;
      repeat (3) @(posedge clk_in);
      #1;
      tslo = 32'h0c0d_e5a1;
      run(cmu_pkg::OP_ST_TAG, cmu_pkg::TGT_I);
      for (int o = 0; o < 8; o++)
         for (int t = 0; t < 4; t++)
         begin
            rnd();
            run(o[2:0], t[1:0]);
         end
      flag = 1'b0;
      run(cmu_pkg::OP_IDX_INV, cmu_pkg::TGT_D);
      flag = 1'b1;
      incl = 1'b0;
      run(cmu_pkg::OP_IDX_INV, cmu_pkg::TGT_D);
      run(cmu_pkg::OP_IDX_INV, cmu_pkg::TGT_S);
      for (int n = 0; n < 24; n++)
      begin
         rnd();
         run({1'b0, lfsr[6:5]}, lfsr[8:7]);
      end
      end_of_test();
   end
endmodule
`default_nettype wire

// ==== cmu_cache_model.sv ====
// behavioural model of the cache arrays and memory behind the unit
`timescale 1ns/1ps
`default_nettype none
module cmu_cache_model
(
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        cache_req_in,
   input  wire logic [1:0]  cache_sel_in,
   input  wire logic [1:0]  cache_cmd_in,
   input  wire logic        wb_req_in,
   input  wire logic [1:0]  dly_in,
   input  wire logic        dirty_in,
   input  wire logic        wb_err_in,
   input  wire logic        stall_in,
   output var  logic        cache_ack_out,
   output var  logic        wb_ack_out,
   output var  logic [15:0] inv_n_out,
   output var  logic [15:0] wr_n_out,
   output var  logic [15:0] wb_n_out,
   output logic             valid_out,
   output logic             dirty_out,
   output logic             wb_err_out,
   output logic             mem_idle_out,
   output logic [31:0]      tag_lo_out,
   output logic [31:0]      tag_hi_out,
   output logic [31:0]      data_lo_out,
   output logic [31:0]      data_hi_out
);
   logic [1:0]  cnt_q;
   logic [1:0]  sel_q;
   logic [2:0]  idle_q;
   logic [31:0] tv;

   // off the ack edge lines show inverted values, so stale data never matches
   assign tv           = 32'h7a5c_0000 + {30'h0, sel_q};
   assign tag_lo_out   = cache_ack_out ? tv : ~tv;
   assign tag_hi_out   = cache_ack_out ? {tv[27:0], 4'h0} : ~{tv[27:0], 4'h0};
   assign data_lo_out  = cache_ack_out ? (tv ^ 32'h00ff_00ff) : ~(tv ^ 32'h00ff_00ff);
   assign data_hi_out  = ~data_lo_out;
   assign valid_out    = cache_ack_out;
   assign dirty_out    = cache_ack_out ? dirty_in : ~dirty_in;
   assign wb_err_out   = wb_ack_out ? wb_err_in : ~wb_err_in;
   assign mem_idle_out = idle_q == 3'h0;

   // answer a held request after dly_in cycles, one pulse each
   always_ff @(posedge clk_in or negedge rst_b_in)
      if (!rst_b_in)
      begin
         {cache_ack_out, wb_ack_out, cnt_q, sel_q, idle_q} <= '0;
         {inv_n_out, wr_n_out, wb_n_out} <= '0;
      end
      else
      begin
         cache_ack_out <= 1'b0;
         wb_ack_out    <= 1'b0;
         if (stall_in)
            idle_q <= 3'h4;
         else if (idle_q != 3'h0)
            idle_q <= idle_q - 3'h1;
         if ((cache_req_in && !cache_ack_out) || (wb_req_in && !wb_ack_out))
         begin
            if (cnt_q < dly_in)
               cnt_q <= cnt_q + 2'h1;
            else
            begin
               cnt_q <= 2'h0;
               if (wb_req_in)
               begin
                  wb_ack_out <= 1'b1;
                  wb_n_out   <= wb_n_out + 16'h1;
                  idle_q     <= 3'h2;
               end
               else
               begin
                  cache_ack_out <= 1'b1;
                  sel_q         <= cache_sel_in;
                  inv_n_out     <= inv_n_out + {15'h0, cache_cmd_in == cmu_pkg::CMD_INV};
                  wr_n_out      <= wr_n_out + {15'h0, cache_cmd_in == cmu_pkg::CMD_WR_TAG};
               end
            end
         end
      end
endmodule
`default_nettype wire

// ==== cmu_ea_gen.sv ====
// effective address adder
`timescale 1ns/1ps
`default_nettype none
module cmu_ea_gen
(
   input  wire logic [31:0]            base_in,
   input  wire logic [cmu_pkg::OFS_W-1:0] ofs_in,
   output var  logic [31:0]            ea_out
);
   always_comb
   begin
      ea_out = base_in + {{(32-cmu_pkg::OFS_W){ofs_in[cmu_pkg::OFS_W-1]}}, ofs_in};
   end
endmodule
`default_nettype wire

// ==== cmu_pkg.sv ====
// constants, state encodings and decode helpers of the cache maintenance unit
//----------------------------------------------------------------------------
// Operation
// - the instruction and its writebacks obey full barrier ordering and completion.
// - target bits 22:21 pick instruction, data, tertiary or secondary cache.
// - a three-bit op field selects the action; required codes always work.
// - with inclusion, an outer-cache operation first runs on the inner cache; the unit does this only for op 000.
// - hit operations broadcast only for coherent attributes, never for non-coherent.
// - all levels touched by one instruction share the same broadcast choice.
// - in the mapped-user/unmapped-kernel segment, translate through the user mapping.
// - unmapped-all and mapped-user/supervisor segments are reachable too.
// - the instruction exists only when the enhanced addressing flag is one.
// - op 000 on the instruction cache invalidates the indexed block.
// - op 000 on write-back caches writes dirty valid blocks back, then invalidates.
// - op 000 on a write-through cache only invalidates, with no writeback.
// - secondary and tertiary variants apply only where those caches exist.
// - op 001 copies the indexed tag into the low and high tag stages.
// - op 001 also loads the indexed data into the data stages.
// - the tag read never raises a cache error.
// - effective address is base plus the sign-extended nine-bit offset.
// - op 010 writes the indexed tag from the tag stages, never erroring.
//----------------------------------------------------------------------------
package cmu_pkg;

   // instruction fields
   localparam int TGT_LSB = 21;
   localparam int TGT_MSB = 22;
   localparam int OP_LSB  = 23;
   localparam int OP_MSB  = 25;
   localparam int OFS_LSB = 0;
   localparam int OFS_MSB = 8;
   localparam int OFS_W   = 9;

   // target cache codes
   localparam logic [1:0] TGT_I = 2'h0;
   localparam logic [1:0] TGT_D = 2'h1;
   localparam logic [1:0] TGT_T = 2'h2;
   localparam logic [1:0] TGT_S = 2'h3;

   // operation codes handled here
   localparam logic [2:0] OP_IDX_INV = 3'h0;
   localparam logic [2:0] OP_LD_TAG  = 3'h1;
   localparam logic [2:0] OP_ST_TAG  = 3'h2;

   // segment access modes
   localparam logic [1:0] SEG_OTHER = 2'h0;
   localparam logic [1:0] SEG_MAPPED_USER_SUP_UNMAPPED_KERNEL_SEG = 2'h1;
   localparam logic [1:0] SEG_UNMAPPED_ALL_MODES_SEG  = 2'h2;
   localparam logic [1:0] SEG_MAPPED_USER_SUP_SEG  = 2'h3;

   // commands toward the cache arrays
   localparam logic [1:0] CMD_RD_TAG = 2'h0;
   localparam logic [1:0] CMD_WR_TAG = 2'h1;
   localparam logic [1:0] CMD_INV    = 2'h2;

   // which optional levels this build has
   localparam logic L2_PRESENT = 1'b1;
   localparam logic L3_PRESENT = 1'b0;

   // reset values
   localparam logic [31:0] WORD_RST = 32'h0000_0000;

   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_DRAIN = 7'h02,
      ST_READ  = 7'h04,
      ST_WB    = 7'h08,
      ST_INV   = 7'h10,
      ST_STORE = 7'h20,
      ST_DONE  = 7'h40
   } cmu_state_t;

   // level is built into this core
   function automatic logic cmu_present(input logic [1:0] sel);
      case (sel)
         TGT_S:   cmu_present = L2_PRESENT;
         TGT_T:   cmu_present = L3_PRESENT;
         default: cmu_present = 1'b1;
      endcase
   endfunction

   // outer level that keeps the primary data cache as a subset
   function automatic logic cmu_outer(input logic [1:0] sel);
      cmu_outer = (sel == TGT_S) || (sel == TGT_T);
   endfunction

endpackage

// ==== cmu_rst_sync.sv ====
// reset release synchroniser
`timescale 1ns/1ps
`default_nettype none
module cmu_rst_sync
(
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   output var  logic rst_b_out
);
   logic meta_q;

   // assert at once, release after two edges
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         meta_q    <= 1'b0;
         rst_b_out <= 1'b0;
      end
      else
      begin
         meta_q    <= 1'b1;
         rst_b_out <= meta_q;
      end
   end
endmodule
`default_nettype wire
